// ===== sim/isasc_mem.sv
// Purpose: memory beside the executor
// Assumes: slow adds one cycle per access
// Notes: idle read data is inverted
`timescale 1ns/100ps
module isasc_mem (
	input wire ref_clk,
	input wire slow,
	input wire mem_req,
	input wire mem_we,
	input wire [11:0] mem_addr,
	input wire [11:0] mem_wdata,
	output wire mem_ack,
	output wire [11:0] mem_rdata
);
reg [11:0] m [0:4095];
reg w_q;
assign mem_ack = mem_req & (~slow | w_q);
assign mem_rdata = mem_ack ? m[mem_addr] : ~m[mem_addr];
always @(posedge ref_clk) begin
	w_q <= mem_req & ~mem_ack;
	if (mem_ack & mem_we)
		m[mem_addr] <= mem_wdata;
end
endmodule // isasc_mem

// ===== sim/isasc_props.sv
// Purpose: executor checks
// Assumes: fetch is the first read after done
// Notes: bound to isasc_exec
`timescale 1ns/100ps
module isasc_props (
	input wire ref_clk,
	input wire resetn,
	input wire mem_req,
	input wire mem_we,
	input wire [11:0] mem_addr,
	input wire [11:0] mem_wdata,
	input wire mem_ack,
	input wire [11:0] mem_rdata,
	input wire [11:0] pc,
	input wire [11:0] accumulator,
	input wire link,
	input wire instr_done,
	input wire skip_taken
);
reg f_q, s_q;
reg [11:0] ir_q, fa_q, ra_q, rd_q;
wire rd = mem_ack & mem_req & ~mem_we;
wire [2:0] op = ir_q[11:9];
wire [11:0] ea = {ir_q[7] ? fa_q[11:7] : 5'h00, ir_q[6:0]};
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		f_q <= 1'b1;
		s_q <= 1'b0;
		ir_q <= 12'h000;
		fa_q <= 12'h000;
		ra_q <= 12'h000;
		rd_q <= 12'h000;
	end else begin
		f_q <= instr_done | (f_q & ~rd);
		s_q <= skip_taken | (s_q & ~(rd & f_q));
		if (rd) begin
			ra_q <= mem_addr;
			rd_q <= mem_rdata;
		end
		if (rd & f_q) begin
			ir_q <= mem_rdata;
			fa_q <= mem_addr;
		end
	end
end
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!resetn);
property p_keep; mem_req && !f_q && op == 3'h2 |=> $stable(accumulator) && $stable(link); endproperty
a_keep: assert property (p_keep) else $error("acc moved");
property p_wb; mem_we && mem_req && op == 3'h2 |-> mem_addr == ra_q && mem_wdata == rd_q + 12'h001; endproperty
a_wb: assert property (p_wb) else $error("bad writeback");
property p_skip; skip_taken |-> mem_we && mem_wdata == 12'h000; endproperty
a_skip: assert property (p_skip) else $error("bad skip");
property p_pc2; instr_done && op == 3'h2 |-> pc == fa_q + (s_q ? 12'h002 : 12'h001); endproperty
a_pc2: assert property (p_pc2) else $error("bad pc");
property p_call; mem_we && mem_req && op == 3'h4 |-> mem_wdata == fa_q + 12'h001; endproperty
a_call: assert property (p_call) else $error("bad link");
property p_cpc; instr_done && op == 3'h4 && !ir_q[8] |-> pc == ea + 12'h001; endproperty
a_cpc: assert property (p_cpc) else $error("bad entry");
property p_ea; mem_req && !f_q && !ir_q[8] |-> mem_addr == ea; endproperty
a_ea: assert property (p_ea) else $error("bad address");
property p_ret; instr_done && op == 3'h5 && ir_q[8] |-> pc == rd_q; endproperty
a_ret: assert property (p_ret) else $error("bad return");
c_skip: cover property (skip_taken);
c_call: cover property (instr_done && op == 3'h4);
c_ret: cover property (instr_done && op == 3'h5);
endmodule // isasc_props
bind isasc_exec isasc_props u_props (
	.ref_clk     (ref_clk),
	.resetn      (resetn),
	.mem_req     (mem_req),
	.mem_we      (mem_we),
	.mem_addr    (mem_addr),
	.mem_wdata   (mem_wdata),
	.mem_ack     (mem_ack),
	.mem_rdata   (mem_rdata),
	.pc          (pc),
	.accumulator (accumulator),
	.link        (link),
	.instr_done  (instr_done),
	.skip_taken  (skip_taken)
);

// ===== sim/test_increment_skip_and_subroutine_call.sv
// Purpose: executor scenarios
// Assumes: memory preloaded by hierarchy
// Notes: one instruction per step
`timescale 1ns/100ps
module test_increment_skip_and_subroutine_call;
reg ref_clk, resetn, run, pc_load, slow;
reg [11:0] pc_load_value;
wire mem_req, mem_we, mem_ack, link, instr_done, skip_taken;
wire [11:0] mem_addr, mem_wdata, mem_rdata, pc, accumulator;
integer failures, checks, cyc;
reg saw_skip;
isasc_exec dut (
	.ref_clk       (ref_clk),
	.resetn        (resetn),
	.run           (run),
	.pc_load       (pc_load),
	.pc_load_value (pc_load_value),
	.mem_req       (mem_req),
	.mem_we        (mem_we),
	.mem_addr      (mem_addr),
	.mem_wdata     (mem_wdata),
	.mem_ack       (mem_ack),
	.mem_rdata     (mem_rdata),
	.pc            (pc),
	.accumulator   (accumulator),
	.link          (link),
	.instr_done    (instr_done),
	.skip_taken    (skip_taken)
);
isasc_mem mem (
	.ref_clk   (ref_clk),
	.slow      (slow),
	.mem_req   (mem_req),
	.mem_we    (mem_we),
	.mem_addr  (mem_addr),
	.mem_wdata (mem_wdata),
	.mem_ack   (mem_ack),
	.mem_rdata (mem_rdata)
);
initial begin
	ref_clk = 1'b0;
	forever #25 ref_clk = ~ref_clk;
end
task end_of_test;
begin
	$display("checks %0d failures %0d", checks, failures);
	if (failures == 0 && checks > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
end
endtask
always @(posedge ref_clk) begin
	cyc = cyc + 1;
	if (cyc == 3000) begin
		failures = failures + 1;
		$display("MISMATCH %0t run timed out", $time);
		end_of_test;
	end
end
task cmp(input [11:0] got, input [11:0] exp);
begin
	checks = checks + 1;
	if (got !== exp) begin
		failures = failures + 1;
		$display("MISMATCH %0t got %h exp %h", $time, got, exp);
	end
end
endtask
task step(input [11:0] a, input [11:0] ins);
integer n;
begin
	mem.m[a] = ins;
	saw_skip = 1'b0;
	@(posedge ref_clk);
	pc_load <= 1'b1;
	pc_load_value <= a;
	@(posedge ref_clk);
	pc_load <= 1'b0;
	run <= 1'b1;
	@(posedge ref_clk);
	run <= 1'b0;
	n = 0;
	while (instr_done !== 1'b1 && n < 40) begin
		@(negedge ref_clk);
		if (skip_taken === 1'b1)
			saw_skip = 1'b1;
		n = n + 1;
	end
	if (n == 40) begin
		failures = failures + 1;
		$display("MISMATCH %0t instruction never ended", $time);
	end
end
endtask
// two adds load accumulator and link, then a wrapping increment-skip
task scen_wrap;
begin
	mem.m[12'h010] = 12'hFFF;
	step(12'h080, 12'h210);
	step(12'h080, 12'h210);
	step(12'h080, 12'h410);
	cmp(mem.m[12'h010], 12'h000);
	cmp(pc, 12'h082);
	cmp({11'h000, saw_skip}, 12'h001);
	cmp(accumulator, 12'hFFE);
	cmp({11'h000, link}, 12'h001);
end
endtask
// and, deposit and no-op reached from page two
task scen_other;
begin
	mem.m[12'h011] = 12'h0F0;
	mem.m[12'h012] = 12'h555;
	step(12'h100, 12'h011);
	cmp(accumulator, 12'h0F0);
	step(12'h101, 12'h612);
	cmp(mem.m[12'h012], 12'h0F0);
	cmp(accumulator, 12'h000);
	step(12'h102, 12'hE00);
	cmp(pc, 12'h103);
end
endtask
// current-page increment without skip, slow memory
task scen_page;
begin
	slow = 1'b1;
	mem.m[12'h311] = 12'h7FF;
	step(12'h345, 12'h491);
	cmp(mem.m[12'h311], 12'h800);
	cmp(pc, 12'h346);
	cmp({11'h000, saw_skip}, 12'h000);
	slow = 1'b0;
end
endtask
// call, then return through the stored word
task scen_call;
begin
	mem.m[12'h5C4] = 12'h777;
	step(12'h5A0, 12'h8C4);
	cmp(mem.m[12'h5C4], 12'h5A1);
	cmp(pc, 12'h5C5);
	step(12'h5C9, 12'hBC4);
	cmp(pc, 12'h5A1);
end
endtask
// indirect increment-skip through a page-zero pointer
task scen_indirect;
begin
	mem.m[12'h01E] = 12'h9AB;
	mem.m[12'h9AB] = 12'hFFF;
	step(12'hE05, 12'h51E);
	cmp(mem.m[12'h9AB], 12'h000);
	cmp(mem.m[12'h01E], 12'h9AB);
	cmp(pc, 12'hE07);
	cmp({11'h000, saw_skip}, 12'h001);
end
endtask
initial begin
	resetn = 1'b0;
	run = 1'b0;
	pc_load = 1'b0;
	slow = 1'b0;
	pc_load_value = 12'h000;
	saw_skip = 1'b0;
	failures = 0;
	checks = 0;
	cyc = 0;
	repeat (8) @(posedge ref_clk);
	resetn <= 1'b1;
	scen_wrap;
	scen_other;
	scen_page;
	scen_call;
	scen_indirect;
	end_of_test;
end
endmodule // test_increment_skip_and_subroutine_call

// ===== verilog/isasc_defs.vh
// Purpose: shared constants of the memory-reference executor
// Assumes: 12-bit words, 128-word pages, bit 0 is the least significant bit
// Notes:   included by the executor and its address former
//
// Summary of operation
// RL1: increment-skip keeps accumulator and link unchanged
// RL2: incremented word written back to same location
// RL3: increment first, skip only on zero result
// RL4: increment wraps, all ones becomes zero, skips
// RL5: subroutine call stores next address at target
// RL6: call continues at target plus one
// RL7: indirect jump returns via stored subroutine word
// RL8: indirect reference uses pointer word as address
// RL9: direct address: page zero or current page
// RL10: page zero reachable from every page
// RL11: skip advances program counter by two words
`ifndef ISASC_DEFS_VH
`define ISASC_DEFS_VH

// ----------------------------------------------------------------
// word and instruction fields
// ----------------------------------------------------------------
`define ISASC_WORD_W      12
`define ISASC_OP_HI       11
`define ISASC_OP_LO       9
`define ISASC_IND_BIT     8
`define ISASC_PAGE_BIT    7
`define ISASC_OFS_HI      6
`define ISASC_PAGE_HI     11
`define ISASC_PAGE_LO     7
`define ISASC_PAGE_ZERO   5'h00

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define ISASC_OP_AND      3'h0
`define ISASC_OP_ADD      3'h1
`define ISASC_OP_INCSKIP  3'h2
`define ISASC_OP_DEPOSIT  3'h3
`define ISASC_OP_CALL     3'h4
`define ISASC_OP_JUMP     3'h5

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define ISASC_PC_RST      12'h080
`define ISASC_WORD_ZERO   12'h000
`define ISASC_WORD_ONE    12'h001

`endif

// ===== verilog/isasc_ea.v
// Purpose: forms the direct effective address of a memory-reference instruction
// Assumes: instruction and its own address are both valid in the same cycle
// Notes:   purely combinational
`timescale 1ns/100ps
`include "isasc_defs.vh"

module isasc_ea (
	input  wire [`ISASC_WORD_W-1:0] instr,
	input  wire [`ISASC_WORD_W-1:0] instr_addr,
	output wire [`ISASC_WORD_W-1:0] direct_addr
);

	// ----------------------------------------------------------------
	// page select
	// ----------------------------------------------------------------
	wire [`ISASC_PAGE_HI-`ISASC_PAGE_LO:0] page_sel;

	assign page_sel    = instr[`ISASC_PAGE_BIT] ? instr_addr[`ISASC_PAGE_HI:`ISASC_PAGE_LO]
	                                            : `ISASC_PAGE_ZERO; // RL9 RL10
	assign direct_addr = {page_sel, instr[`ISASC_OFS_HI:0]}; // RL9

endmodule // isasc_ea

// ===== verilog/isasc_exec.v
// Purpose: fetch and execute of memory-reference instructions
// Assumes: memory answers a held request with a one-cycle ack
// Notes:   opcodes 6 and 7 are passed over as no-operations
`timescale 1ns/100ps
`include "isasc_defs.vh"

module isasc_exec #(
	parameter W = `ISASC_WORD_W
) (
	input  wire         ref_clk,
	input  wire         resetn,
	input  wire         run,
	input  wire         pc_load,
	input  wire [W-1:0] pc_load_value,
	output wire         mem_req,
	output wire         mem_we,
	output wire [W-1:0] mem_addr,
	output wire [W-1:0] mem_wdata,
	input  wire         mem_ack,
	input  wire [W-1:0] mem_rdata,
	output wire [W-1:0] pc,
	output wire [W-1:0] accumulator,
	output wire         link,
	output wire         instr_done,
	output wire         skip_taken
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_FETCH = 3'h1;
	localparam [2:0] S_IND   = 3'h2;
	localparam [2:0] S_EXEC  = 3'h3;
	localparam [2:0] S_RD    = 3'h4;
	localparam [2:0] S_WR    = 3'h5;

	reg  [2:0]   state_q;
	reg  [2:0]   state_d;
	reg  [W-1:0] pc_q;
	reg  [W-1:0] ir_q;
	reg  [W-1:0] ea_q;
	reg  [W-1:0] addr_q;
	reg  [W-1:0] wdata_q;
	reg  [W-1:0] acc_q;
	reg          link_q;
	reg          done_q;
	reg          skip_q;
	wire [W-1:0] direct_addr;
	wire [W-1:0] incr_word;
	wire [W:0]   add_sum;
	wire [2:0]   op;
	wire [2:0]   fetch_op;
	wire         fetch_nop;
	wire         fetch_ind;
	wire         incr_zero;

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	assign op        = ir_q[`ISASC_OP_HI:`ISASC_OP_LO];
	assign fetch_op  = mem_rdata[`ISASC_OP_HI:`ISASC_OP_LO];
	assign fetch_nop = (fetch_op > `ISASC_OP_JUMP);
	assign fetch_ind = mem_rdata[`ISASC_IND_BIT]; // RL8
	assign incr_word = mem_rdata + `ISASC_WORD_ONE; // RL3 RL4
	assign incr_zero = (incr_word == `ISASC_WORD_ZERO); // RL3
	assign add_sum   = {1'b0, acc_q} + {1'b0, mem_rdata};

	// ----------------------------------------------------------------
	// address former
	// ----------------------------------------------------------------
	isasc_ea u_ea (
		.instr       (mem_rdata),
		.instr_addr  (pc_q),
		.direct_addr (direct_addr)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
		S_IDLE: begin
			if (!pc_load && run) begin
				state_d = S_FETCH;
			end
		end
		S_FETCH: begin
			if (mem_ack) begin
				if (fetch_nop) begin
					state_d = S_IDLE;
				end else if (fetch_ind) begin
					state_d = S_IND;
				end else begin
					state_d = S_EXEC;
				end
			end
		end
		S_IND: begin
			if (mem_ack) begin
				state_d = S_EXEC;
			end
		end
		S_EXEC: begin
			case (op)
			`ISASC_OP_JUMP: begin
				state_d = S_IDLE;
			end
			`ISASC_OP_CALL,
			`ISASC_OP_DEPOSIT: begin
				state_d = S_WR;
			end
			default: begin
				state_d = S_RD;
			end
			endcase
		end
		S_RD: begin
			if (mem_ack) begin
				if (op == `ISASC_OP_INCSKIP) begin
					state_d = S_WR; // RL2
				end else begin
					state_d = S_IDLE;
				end
			end
		end
		S_WR: begin
			if (mem_ack) begin
				state_d = S_IDLE;
			end
		end
		default: begin
			state_d = S_IDLE;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// datapath registers
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= S_IDLE;
			pc_q    <= `ISASC_PC_RST;
			ir_q    <= `ISASC_WORD_ZERO;
			ea_q    <= `ISASC_WORD_ZERO;
			addr_q  <= `ISASC_WORD_ZERO;
			wdata_q <= `ISASC_WORD_ZERO;
			acc_q   <= `ISASC_WORD_ZERO;
			link_q  <= 1'b0;
			done_q  <= 1'b0;
			skip_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q  <= 1'b0;
			skip_q  <= 1'b0;
			case (state_q)
			S_IDLE: begin
				if (pc_load) begin
					pc_q <= pc_load_value;
				end else if (run) begin
					addr_q <= pc_q;
				end
			end
			S_FETCH: begin
				if (mem_ack) begin
					ir_q <= mem_rdata;
					pc_q <= pc_q + `ISASC_WORD_ONE;
					if (fetch_nop) begin
						done_q <= 1'b1;
					end else if (fetch_ind) begin
						addr_q <= direct_addr; // RL8
					end else begin
						ea_q <= direct_addr; // RL9
					end
				end
			end
			S_IND: begin
				if (mem_ack) begin
					ea_q <= mem_rdata; // RL8 RL7
				end
			end
			S_EXEC: begin
				addr_q <= ea_q;
				case (op)
				`ISASC_OP_JUMP: begin
					pc_q   <= ea_q; // RL7
					done_q <= 1'b1;
				end
				`ISASC_OP_CALL: begin
					wdata_q <= pc_q; // RL5
					pc_q    <= ea_q + `ISASC_WORD_ONE; // RL6
				end
				`ISASC_OP_DEPOSIT: begin
					wdata_q <= acc_q;
					acc_q   <= `ISASC_WORD_ZERO;
				end
				default: begin
					// operand read follows
				end
				endcase
			end
			S_RD: begin
				if (mem_ack) begin
					case (op)
					`ISASC_OP_AND: begin
						acc_q  <= acc_q & mem_rdata;
						done_q <= 1'b1;
					end
					`ISASC_OP_ADD: begin
						acc_q  <= add_sum[W-1:0];
						link_q <= link_q ^ add_sum[W];
						done_q <= 1'b1;
					end
					default: begin
						// accumulator and link are left alone here
						wdata_q <= incr_word; // RL1 RL2
						if (incr_zero) begin
							pc_q   <= pc_q + `ISASC_WORD_ONE; // RL3 RL11
							skip_q <= 1'b1;
						end
					end
					endcase
				end
			end
			S_WR: begin
				if (mem_ack) begin
					done_q <= 1'b1; // RL2
				end
			end
			default: begin
				done_q <= 1'b0;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign mem_req     = (state_q == S_FETCH) || (state_q == S_IND) ||
	                     (state_q == S_RD) || (state_q == S_WR);
	assign mem_we      = (state_q == S_WR);
	assign mem_addr    = addr_q;
	assign mem_wdata   = wdata_q;
	assign pc          = pc_q;
	assign accumulator = acc_q;
	assign link        = link_q;
	assign instr_done  = done_q;
	assign skip_taken  = skip_q;

endmodule // isasc_exec
